// ==== rsv_pkg.sv ====
// Purpose: Shared constants and types for the start/stop velocity ramp
// Assumes: Register index times four gives the Avalon byte address
// Notes: Velocity limit and current velocity are signed; other velocities and accelerations are unsigned magnitudes per clock
package rsv_pkg;

  ////////////////////////////////////////////////////////////////////////
  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  localparam int IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_GENERAL_CONFIG = 8'h00;
  localparam logic [IDX_W-1:0] IDX_PROFILE = 8'h20;
  localparam logic [IDX_W-1:0] IDX_VELOCITY_LIMIT = 8'h24;
  localparam logic [IDX_W-1:0] IDX_START_VELOCITY = 8'h25;
  localparam logic [IDX_W-1:0] IDX_STOP_VELOCITY = 8'h26;
  localparam logic [IDX_W-1:0] IDX_BREAK_VELOCITY = 8'h27;
  localparam logic [IDX_W-1:0] IDX_PEAK_ACCEL = 8'h28;
  localparam logic [IDX_W-1:0] IDX_PEAK_DECEL = 8'h29;
  localparam logic [IDX_W-1:0] IDX_INIT_ACCEL = 8'h2a;
  localparam logic [IDX_W-1:0] IDX_FINAL_DECEL = 8'h2b;
  localparam logic [IDX_W-1:0] IDX_JERK1 = 8'h2c;
  localparam logic [IDX_W-1:0] IDX_JERK2 = 8'h2d;
  localparam logic [IDX_W-1:0] IDX_JERK3 = 8'h2f;
  localparam logic [IDX_W-1:0] IDX_JERK4 = 8'h30;
  localparam logic [IDX_W-1:0] IDX_CURRENT_VELOCITY = 8'h40;
  localparam logic [IDX_W-1:0] IDX_RAMP_STATUS = 8'h41;

  ////////////////////////////////////////////////////////////////////////
  localparam int GC_ACCEL_START_BIT = 0;
  localparam int PROF_POS_BIT = 2;
  localparam logic [1:0] PROF_TRAP = 2'h1;
  localparam logic [1:0] PROF_SHAPE = 2'h2;
  localparam logic [DATA_W-1:0] REG_RESET = 32'h0;

  typedef enum logic [3:0] {
    PH_STAND, PH_JERK1, PH_ACONST, PH_JERK2,
    PH_CRUISE, PH_JERK3, PH_DCONST, PH_JERK4
  } rsv_phase_type;

  typedef struct packed {
    logic [DATA_W-1:0] limit;
    logic [DATA_W-1:0] start;
    logic [DATA_W-1:0] stop;
    logic [DATA_W-1:0] brk;
    logic [DATA_W-1:0] pacc;
    logic [DATA_W-1:0] pdec;
    logic [DATA_W-1:0] iacc;
    logic [DATA_W-1:0] fdec;
    logic [DATA_W-1:0] j1;
    logic [DATA_W-1:0] j2;
    logic [DATA_W-1:0] j3;
    logic [DATA_W-1:0] j4;
  } rsv_params_type;

endpackage

// ==== rsv_slope.sv ====
// Purpose: One velocity step toward a bound, saturating on arrival
// Assumes: Magnitudes are unsigned
// Notes: Rising adds, falling subtracts; hit marks the bound reached
module rsv_slope #(
  parameter int W = 32
) (
  input wire logic [W-1:0] mag,
  input wire logic [W-1:0] step,
  input wire logic [W-1:0] bound,
  input wire logic rise,
  output logic [W-1:0] nxt,
  output logic hit
);

  wire [W:0] sum = {1'b0, mag} + {1'b0, step};
  wire [W:0] dif = {1'b0, mag} - {1'b0, step};
  wire rise_hit = sum >= {1'b0, bound};
  wire fall_hit = dif[W] || (dif[W-1:0] <= bound);

  // Saturation keeps the step from jumping past the bound
  assign hit = rise ? rise_hit : fall_hit;
  assign nxt = hit ? bound : (rise ? sum[W-1:0] : dif[W-1:0]);

endmodule // rsv_slope

// ==== rsv_ramp.sv ====
// Purpose: Start and stop velocity handling of a motion ramp generator
// Assumes: Avalon-MM slave, one wait cycle per access; pos input same clock
// Notes: Acceleration and jerk apply every clock, not every 64 clocks

module rsv_ramp (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [rsv_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rsv_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [rsv_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pos_target_reached,
  output logic [rsv_pkg::DATA_W-1:0] current_velocity,
  output rsv_pkg::rsv_phase_type ramp_phase,
  output logic ramp_done
);

  localparam int W = rsv_pkg::DATA_W;

  function automatic logic [W-1:0] merge(input logic [W-1:0] old,
                                         input logic [W-1:0] nw,
                                         input logic [3:0] be);
    logic [W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // True when the remaining gap fits the jerk-limited wind-down
  function automatic logic near(input logic [W-1:0] gap,
                                input logic [W-1:0] acc,
                                input logic [W-1:0] jerk);
    logic [2*W-1:0] pg;
    logic [2*W-1:0] pa;
    pg = (2*W)'(gap) * (2*W)'(jerk);
    pa = (2*W)'(acc) * (2*W)'(acc);
    return {pg[2*W-2:0], 1'b0} <= pa;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register bus
  logic ack_q;
  logic [W-1:0] rdata_q;
  logic [W-1:0] gc_q;
  logic [W-1:0] prof_q;
  rsv_pkg::rsv_params_type par_q;
  rsv_pkg::rsv_params_type par_d;
  logic [W-1:0] vel_q;
  rsv_pkg::rsv_phase_type ph_q;
  rsv_pkg::rsv_phase_type ph_d;
  logic done_q;

  wire req = avs_read | avs_write;
  wire [rsv_pkg::IDX_W-1:0] idx = avs_address[rsv_pkg::ADDR_W-1:2];
  wire wr_go = avs_write & ack_q;
  wire gc_wr = wr_go && idx == rsv_pkg::IDX_GENERAL_CONFIG;
  wire prof_wr = wr_go && idx == rsv_pkg::IDX_PROFILE;

  // One wait cycle lets read data come from a flop
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;

  function automatic logic [W-1:0] rd(input logic [rsv_pkg::IDX_W-1:0] a);
    case (a)
      rsv_pkg::IDX_GENERAL_CONFIG: rd = gc_q;
      rsv_pkg::IDX_PROFILE: rd = prof_q;
      rsv_pkg::IDX_VELOCITY_LIMIT: rd = par_q.limit;
      rsv_pkg::IDX_START_VELOCITY: rd = par_q.start;
      rsv_pkg::IDX_STOP_VELOCITY: rd = par_q.stop;
      rsv_pkg::IDX_BREAK_VELOCITY: rd = par_q.brk;
      rsv_pkg::IDX_PEAK_ACCEL: rd = par_q.pacc;
      rsv_pkg::IDX_PEAK_DECEL: rd = par_q.pdec;
      rsv_pkg::IDX_INIT_ACCEL: rd = par_q.iacc;
      rsv_pkg::IDX_FINAL_DECEL: rd = par_q.fdec;
      rsv_pkg::IDX_JERK1: rd = par_q.j1;
      rsv_pkg::IDX_JERK2: rd = par_q.j2;
      rsv_pkg::IDX_JERK3: rd = par_q.j3;
      rsv_pkg::IDX_JERK4: rd = par_q.j4;
      rsv_pkg::IDX_CURRENT_VELOCITY: rd = vel_q;
      rsv_pkg::IDX_RAMP_STATUS: rd = W'(ph_q);
      default: rd = rsv_pkg::REG_RESET;
    endcase
  endfunction

  always_comb
  begin
    par_d = par_q;
    if (wr_go)
    begin
      case (idx)
        rsv_pkg::IDX_VELOCITY_LIMIT:
          par_d.limit = merge(par_q.limit, avs_writedata, avs_byteenable);
        rsv_pkg::IDX_START_VELOCITY:
          par_d.start = merge(par_q.start, avs_writedata, avs_byteenable);
        rsv_pkg::IDX_STOP_VELOCITY:
          par_d.stop = merge(par_q.stop, avs_writedata, avs_byteenable);
        rsv_pkg::IDX_BREAK_VELOCITY:
          par_d.brk = merge(par_q.brk, avs_writedata, avs_byteenable);
        rsv_pkg::IDX_PEAK_ACCEL:
          par_d.pacc = merge(par_q.pacc, avs_writedata, avs_byteenable);
        rsv_pkg::IDX_PEAK_DECEL:
          par_d.pdec = merge(par_q.pdec, avs_writedata, avs_byteenable);
        rsv_pkg::IDX_INIT_ACCEL:
          par_d.iacc = merge(par_q.iacc, avs_writedata, avs_byteenable);
        rsv_pkg::IDX_FINAL_DECEL:
          par_d.fdec = merge(par_q.fdec, avs_writedata, avs_byteenable);
        rsv_pkg::IDX_JERK1:
          par_d.j1 = merge(par_q.j1, avs_writedata, avs_byteenable);
        rsv_pkg::IDX_JERK2:
          par_d.j2 = merge(par_q.j2, avs_writedata, avs_byteenable);
        rsv_pkg::IDX_JERK3:
          par_d.j3 = merge(par_q.j3, avs_writedata, avs_byteenable);
        rsv_pkg::IDX_JERK4:
          par_d.j4 = merge(par_q.j4, avs_writedata, avs_byteenable);
        default: par_d = par_q;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ack_q <= 1'b0;
      rdata_q <= rsv_pkg::REG_RESET;
      gc_q <= rsv_pkg::REG_RESET;
      prof_q <= rsv_pkg::REG_RESET;
      par_q <= '0;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      rdata_q <= rd(idx);
      if (gc_wr)
        gc_q <= merge(gc_q, avs_writedata, avs_byteenable);
      if (prof_wr)
        prof_q <= merge(prof_q, avs_writedata, avs_byteenable);
      par_q <= par_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Ramp engine, magnitude plus direction
  logic [W-1:0] mag_q;
  logic [W-1:0] mag_d;
  logic [W-1:0] acc_q;
  logic [W-1:0] acc_d;
  logic dir_q;
  logic dir_d;
  logic done_d;
  logic [W-1:0] up_nxt;
  logic [W-1:0] dn_nxt;
  logic up_hit;
  logic dn_hit;

  wire is_s = prof_q[1:0] == rsv_pkg::PROF_SHAPE;
  wire pos_mode = prof_q[rsv_pkg::PROF_POS_BIT];
  wire astart_on = gc_q[rsv_pkg::GC_ACCEL_START_BIT];
  wire [W-1:0] tgt = (pos_mode && pos_target_reached) ? '0 : par_q.limit;
  wire tgt_neg = tgt[W-1];
  wire [W-1:0] tgt_mag = tgt_neg ? W'(-tgt) : tgt;
  wire to_zero = tgt_mag == '0 || tgt_neg != dir_q;
  wire want_down = mag_q != '0 && (to_zero || tgt_mag < mag_q);
  wire want_up = !to_zero && tgt_mag > mag_q;
  wire [W-1:0] dn_bound = to_zero ? par_q.stop : tgt_mag;
  wire below_brk = par_q.brk != '0 && mag_q < par_q.brk;
  wire [W-1:0] up_step = is_s ? acc_q : (below_brk ? par_q.iacc : par_q.pacc);
  wire [W-1:0] dn_step = is_s ? acc_q :
    ((par_q.brk != '0 && mag_q <= par_q.brk) ? par_q.fdec : par_q.pdec);
  wire [W-1:0] acc_j1 = acc_q + par_q.j1;
  wire [W-1:0] acc_j3 = acc_q + par_q.j3;
  wire [W-1:0] acc_j2 = acc_q > par_q.j2 ? acc_q - par_q.j2 : '0;
  // Floor of one keeps a zero final deceleration from stalling
  wire [W-1:0] dec_floor = par_q.fdec == '0 ? W'(1) : par_q.fdec;
  wire [W-1:0] acc_j4 = acc_q > dec_floor + par_q.j4 ?
    acc_q - par_q.j4 : dec_floor;
  wire keep_peak = to_zero && par_q.stop != '0;
  wire [W-1:0] start_mag = par_q.start > tgt_mag ? tgt_mag : par_q.start;
  wire [W-1:0] vel_d = dir_d ? W'(-mag_d) : mag_d;

  rsv_slope #(.W(W)) u_up (
    .mag(mag_q),
    .step(up_step),
    .bound(tgt_mag),
    .rise(1'b1),
    .nxt(up_nxt),
    .hit(up_hit)
  );

  rsv_slope #(.W(W)) u_dn (
    .mag(mag_q),
    .step(dn_step),
    .bound(dn_bound),
    .rise(1'b0),
    .nxt(dn_nxt),
    .hit(dn_hit)
  );

  always_comb
  begin
    ph_d = ph_q;
    mag_d = mag_q;
    acc_d = acc_q;
    dir_d = dir_q;
    done_d = 1'b0;
    case (ph_q)
      rsv_pkg::PH_STAND:
        if (tgt_mag != '0)
        begin
          dir_d = tgt_neg;
          mag_d = start_mag;
          if (!is_s)
          begin
            ph_d = rsv_pkg::PH_ACONST;
            acc_d = '0;
          end
          else if (par_q.start != '0 && !astart_on)
          begin
            ph_d = rsv_pkg::PH_JERK2;
            acc_d = par_q.pacc;
          end
          else
          begin
            ph_d = rsv_pkg::PH_JERK1;
            acc_d = par_q.iacc;
          end
        end
      rsv_pkg::PH_JERK1, rsv_pkg::PH_ACONST:
        // Acceleration winds down first, else the S-shape breaks
        if (want_down && is_s && acc_q != '0)
          ph_d = rsv_pkg::PH_JERK2;
        else if (want_down)
        begin
          ph_d = is_s ? rsv_pkg::PH_JERK3 : rsv_pkg::PH_DCONST;
          acc_d = '0;
        end
        else
        begin
          mag_d = up_nxt;
          if (ph_q == rsv_pkg::PH_JERK1)
          begin
            acc_d = acc_j1 >= par_q.pacc ? par_q.pacc : acc_j1;
            if (acc_j1 >= par_q.pacc)
              ph_d = rsv_pkg::PH_ACONST;
          end
          else if (!is_s && up_hit)
            ph_d = rsv_pkg::PH_CRUISE;
          else if (is_s && (up_hit || near(tgt_mag - mag_q, acc_q,
                                            par_q.j2)))
            ph_d = rsv_pkg::PH_JERK2;
        end
      rsv_pkg::PH_JERK2:
      begin
        // Runs to zero acceleration even past the target
        mag_d = mag_q + acc_q;
        acc_d = acc_j2;
        if (acc_q == '0)
          ph_d = rsv_pkg::PH_CRUISE;
      end
      rsv_pkg::PH_CRUISE:
      begin
        acc_d = '0;
        if (want_down)
          ph_d = is_s ? rsv_pkg::PH_JERK3 : rsv_pkg::PH_DCONST;
        else if (want_up)
          ph_d = is_s ? rsv_pkg::PH_JERK1 : rsv_pkg::PH_ACONST;
      end
      rsv_pkg::PH_JERK3, rsv_pkg::PH_DCONST, rsv_pkg::PH_JERK4:
        if (want_up)
        begin
          ph_d = rsv_pkg::PH_CRUISE;
          acc_d = '0;
        end
        else if (dn_hit && to_zero && mag_q <= dn_bound)
        begin
          mag_d = '0;
          acc_d = '0;
          ph_d = rsv_pkg::PH_STAND;
          done_d = 1'b1;
        end
        // Land on the stop velocity for one update, then jump to zero
        else if (dn_hit && to_zero)
          mag_d = dn_nxt;
        else if (dn_hit)
        begin
          mag_d = dn_nxt;
          acc_d = '0;
          ph_d = rsv_pkg::PH_CRUISE;
        end
        else
        begin
          mag_d = dn_nxt;
          if (ph_q == rsv_pkg::PH_JERK3)
          begin
            acc_d = acc_j3 >= par_q.pdec ? par_q.pdec : acc_j3;
            if (acc_j3 >= par_q.pdec)
              ph_d = rsv_pkg::PH_DCONST;
          end
          else if (ph_q == rsv_pkg::PH_JERK4)
            acc_d = acc_j4;
          else if (is_s && !keep_peak &&
                   near(mag_q - dn_bound, acc_q, par_q.j4))
            ph_d = rsv_pkg::PH_JERK4;
        end
      default:
        ph_d = rsv_pkg::PH_STAND;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ph_q <= rsv_pkg::PH_STAND;
      mag_q <= '0;
      acc_q <= '0;
      dir_q <= 1'b0;
      vel_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      ph_q <= ph_d;
      mag_q <= mag_d;
      acc_q <= acc_d;
      dir_q <= dir_d;
      vel_q <= vel_d;
      done_q <= done_d;
    end
  end

  assign current_velocity = vel_q;
  assign ramp_phase = ph_q;
  assign ramp_done = done_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_stand_zero;
    ph_q == rsv_pkg::PH_STAND |-> mag_q == '0 && vel_q == '0;
  endproperty
  a_stand_zero: assert property (p_stand_zero)
    else $error("velocity not zero at standstill");

  property p_start_jump;
    ph_q == rsv_pkg::PH_STAND && tgt_mag >= par_q.start && tgt_mag != '0
      |=> mag_q == $past(par_q.start);
  endproperty
  a_start_jump: assert property (p_start_jump)
    else $error("start velocity not loaded in one step");

  property p_s_peak_start;
    ph_q == rsv_pkg::PH_STAND && tgt_mag != '0 && is_s &&
      par_q.start != '0 && !astart_on
      |=> ph_q == rsv_pkg::PH_JERK2 && acc_q == $past(par_q.pacc);
  endproperty
  a_s_peak_start: assert property (p_s_peak_start)
    else $error("S ramp did not start at peak acceleration");

  property p_astart_jerk1;
    ph_q == rsv_pkg::PH_STAND && tgt_mag != '0 && is_s && astart_on
      |=> ph_q == rsv_pkg::PH_JERK1 && acc_q == $past(par_q.iacc);
  endproperty
  a_astart_jerk1: assert property (p_astart_jerk1)
    else $error("combined start did not run first jerk phase");

  property p_stop_jump;
    (ph_q == rsv_pkg::PH_JERK3 || ph_q == rsv_pkg::PH_DCONST ||
      ph_q == rsv_pkg::PH_JERK4) && to_zero && !want_up &&
      mag_q <= par_q.stop
      |=> mag_q == '0 && ph_q == rsv_pkg::PH_STAND && ramp_done;
  endproperty
  a_stop_jump: assert property (p_stop_jump)
    else $error("stop velocity did not end the ramp");

  property p_stop_land;
    (ph_q == rsv_pkg::PH_JERK3 || ph_q == rsv_pkg::PH_DCONST ||
      ph_q == rsv_pkg::PH_JERK4) && to_zero && mag_q > par_q.stop &&
      mag_q - par_q.stop <= dn_step
      |=> mag_q == $past(par_q.stop) && !ramp_done;
  endproperty
  a_stop_land: assert property (p_stop_land)
    else $error("stop velocity skipped before standstill");

  property p_no_jerk4;
    is_s && keep_peak && ph_q == rsv_pkg::PH_DCONST
      |=> ph_q != rsv_pkg::PH_JERK4;
  endproperty
  a_no_jerk4: assert property (p_no_jerk4)
    else $error("fourth jerk phase with stop velocity");

  property p_jerk2_kept;
    ph_q == rsv_pkg::PH_JERK2 && acc_q != '0
      |=> ph_q == rsv_pkg::PH_JERK2 && mag_q == $past(mag_q + acc_q);
  endproperty
  a_jerk2_kept: assert property (p_jerk2_kept)
    else $error("second jerk phase cut short");

  property p_break_slope;
    !is_s && ph_q == rsv_pkg::PH_ACONST && !want_down && below_brk &&
      !up_hit |=> mag_q == $past(mag_q) + $past(par_q.iacc);
  endproperty
  a_break_slope: assert property (p_break_slope)
    else $error("wrong slope below break velocity");

  property p_sign;
    ##1 vel_q == (dir_q ? W'(-mag_q) : mag_q);
  endproperty
  a_sign: assert property (p_sign)
    else $error("velocity sign does not match direction");

endmodule // rsv_ramp

// ==== rsv_host.sv ====
// Purpose: Host model that drives the register bus as an Avalon master
// Assumes: One request at a time; waitrequest sampled at rising edges
// Notes: Request held until waitrequest low; no retry or error path
module rsv_host (
  input wire logic core_clk,
  output logic [rsv_pkg::ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [rsv_pkg::DATA_W-1:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [rsv_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
  end

  ////////////////////////////////////////////////////////////////////////
  // Old values seen at the edge, so no race with the slave's flops
  task automatic acc(input logic we, input logic [7:0] idx,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= {idx, 2'h0};
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= d;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // rsv_host

// ==== rsv_ramp_bench.sv ====
// Purpose: Self-checking bench for the start/stop velocity ramp
// Assumes: Host model drives the bus; fixed seed
// Notes: Slopes need not land exactly on stop velocity; the down step saturates there
module rsv_ramp_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TIMEOUT = 30000;
  logic core_clk;
  logic srst;
  logic pos_target_reached;
  logic [rsv_pkg::ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [rsv_pkg::DATA_W-1:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [rsv_pkg::DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [rsv_pkg::DATA_W-1:0] current_velocity;
  rsv_pkg::rsv_phase_type ramp_phase;
  logic ramp_done;
  int mismatches;
  int n_compared;
  int cycles = 0;
  int i;
  logic [31:0] v;
  logic [31:0] w;
  logic [31:0] st;
  logic [31:0] lim;
  logic [7:0] seen;

  rsv_ramp rsv_ramp_inst (.core_clk, .srst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .pos_target_reached, .current_velocity,
    .ramp_phase, .ramp_done);
  rsv_host rsv_host_inst (.core_clk, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT)
    begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] sv,
    input logic [31:0] ev);
    n_compared++;
    if (sv !== ev)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, ev, sv);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    rsv_host_inst.acc(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx);
    rsv_host_inst.acc(1'b0, idx, 32'h0, w);
  endtask

  function automatic logic [31:0] mag(input logic [31:0] x);
    return x[31] ? -x : x;
  endfunction

  function automatic logic [31:0] first_vel(input logic [31:0] s,
    input logic [31:0] l);
    logic [31:0] m;
    m = (s < mag(l)) ? s : mag(l);
    return l[31] ? -m : m;
  endfunction

  task automatic wait_go();
    for (int k = 0; k < 40; k++)
    begin
      @(negedge core_clk);
      if (ramp_phase !== rsv_pkg::PH_STAND)
        break;
    end
    v = current_velocity;
  endtask

  task automatic wait_ph(input rsv_pkg::rsv_phase_type ph);
    for (int k = 0; k < 400; k++)
    begin
      @(negedge core_clk);
      if (ramp_phase === ph)
        break;
    end
    chk("phase", 32'(ramp_phase), 32'(ph));
  endtask

  // Last magnitude before the jump lands in w
  task automatic wait_done();
    seen = 8'h00;
    for (int k = 0; k < 3000; k++)
    begin
      @(negedge core_clk);
      if (ramp_done === 1'b1)
        break;
      w = mag(current_velocity);
      seen[ramp_phase] = 1'b1;
    end
    chk("done", 32'(ramp_done), 32'h1);
    chk("cleared", current_velocity, 32'h0);
    @(negedge core_clk);
    chk("done pulse", 32'(ramp_done), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    srst = 1'b1;
    pos_target_reached = 1'b0;
    mismatches = 0;
    n_compared = 0;
    v = $urandom(34606);
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    rd(8'h25);
    chk("start reset", w, 32'h0);
    rd(8'h26);
    chk("stop reset", w, 32'h0);
    wr(8'h27, 32'h1234);
    rd(8'h27);
    chk("break rw", w, 32'h1234);
    rd(8'h7f);
    chk("unmapped", w, 32'h0);
    $display("test registers done");
    wr(8'h27, 32'h0);
    wr(8'h28, 32'd5);
    wr(8'h29, 32'd6);
    wr(8'h25, 32'd10);
    wr(8'h20, 32'h1);
    wr(8'h24, 32'd100);
    wait_go();
    chk("first velocity", v, 32'd10);
    @(negedge core_clk);
    chk("peak slope", current_velocity, 32'd15);
    wr(8'h28, 32'd8);
    @(negedge core_clk);
    v = current_velocity;
    @(negedge core_clk);
    chk("new slope", current_velocity - v, 32'd8);
    wait_ph(rsv_pkg::PH_CRUISE);
    chk("cruise", current_velocity, 32'd100);
    wr(8'h26, 32'd40);
    wr(8'h24, 32'h0);
    wait_done();
    chk("stop jump", w, 32'd40);
    $display("test trapezoid done");
    wr(8'h24, 32'hffffff9c);
    wait_go();
    chk("negative start", v, first_vel(10, 32'hffffff9c));
    wait_ph(rsv_pkg::PH_CRUISE);
    wr(8'h24, 32'd100);
    wait_done();
    chk("reverse stop", w, 32'd40);
    chk("reverse start", current_velocity, 32'd10);
    $display("test reversal done");
    wr(8'h24, 32'h0);
    wait_done();
    // Break above stop above start
    wr(8'h27, 32'd50);
    wr(8'h2a, 32'd2);
    wr(8'h2b, 32'd3);
    wr(8'h24, 32'd100);
    wait_go();
    @(negedge core_clk);
    chk("initial slope", current_velocity, 32'd12);
    for (i = 0; i < 60 && current_velocity < 60; i++)
      @(negedge core_clk);
    v = current_velocity;
    @(negedge core_clk);
    chk("upper slope", current_velocity - v, 32'd8);
    wr(8'h24, 32'h0);
    wait_done();
    chk("two slope stop", w, 32'd40);
    $display("test break done");
    wr(8'h27, 32'h0);
    wr(8'h2c, 32'd2);
    wr(8'h2d, 32'd3);
    wr(8'h2f, 32'd2);
    wr(8'h30, 32'd5);
    wr(8'h28, 32'd20);
    wr(8'h29, 32'd20);
    wr(8'h20, 32'h2);
    for (i = 0; i < 2; i++)
    begin
      wr(8'h00, 32'(i));
      wr(8'h24, 32'd400);
      wait_go();
      chk("s start", v, 32'd10);
      chk("s phase", 32'(ramp_phase), i ? 32'h1 : 32'h3);
      wr(8'h24, 32'h0);
      wait_done();
      chk("jerk2 run", 32'(seen[3]), 32'h1);
      chk("no jerk4", 32'(seen[7]), 32'h0);
      if (i == 0)
        chk("s stop", w, 32'd40);
    end
    wr(8'h00, 32'h0);
    $display("test s ramp done");
    wr(8'h20, 32'h5);
    wr(8'h24, 32'd100);
    wait_ph(rsv_pkg::PH_CRUISE);
    @(posedge core_clk);
    pos_target_reached <= 1'b1;
    wait_done();
    chk("target stop", w, 32'd40);
    wr(8'h24, 32'h0);
    @(posedge core_clk);
    pos_target_reached <= 1'b0;
    $display("test positioning done");
    wr(8'h20, 32'h1);
    wr(8'h26, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      st = i ? 1 + $urandom % 50 : 200;
      lim = 60 + $urandom % 200;
      if ($urandom % 2)
        lim = -lim;
      wr(8'h28, 1 + $urandom % 16);
      wr(8'h29, 1 + $urandom % 16);
      // Long travel assumed before start velocity
      wr(8'h25, st);
      wr(8'h24, lim);
      wait_go();
      chk("random start", v, first_vel(st, lim));
      wr(8'h24, 32'h0);
      wait_done();
    end
    $display("test random done");
    end_sim();
  end
endmodule // rsv_ramp_bench
